// [common/pgw_pkg.sv]
// register map, field positions, reset values and timing for the
// pushbutton / general / watchdog / configuration register bank
// assumes one 200 MHz clock and a byte-wide register port in front
package pgw_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] PGW_ADDR_GLOBAL  = 8'h1A;
  localparam logic [7:0] PGW_ADDR_IDENT   = 8'h1B;
  localparam logic [7:0] PGW_ADDR_TAKEOVR = 8'h1C;
  localparam logic [7:0] PGW_ADDR_WDCNT   = 8'h1E;
  localparam logic [7:0] PGW_ADDR_SWMODE  = 8'h1F;
  localparam logic [7:0] PGW_ADDR_PROGRAM = 8'h23;
  localparam logic [7:0] PGW_ADDR_DUTY    = 8'h24;
  localparam logic [7:0] PGW_ADDR_MISC2   = 8'h29;
  localparam logic [7:0] PGW_ADDR_CURLIM  = 8'h2A;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int PGW_BIT_CLEAR_ALL_INTERRUPTS   = 7;
  localparam int PGW_BIT_SOFT_RST  = 4;
  localparam int PGW_BIT_PORT_RST  = 0;
  localparam int PGW_BIT_TAKEOVER  = 0;
  localparam int PGW_BIT_WD_EN     = 7;
  localparam int PGW_BIT_WD_IRQ_EN = 6;
  localparam int PGW_BIT_FALLBACK  = 0;
  localparam int PGW_BIT_LARGE_CAP = 5;
  localparam int PGW_BIT_DET_BYP   = 4;
  localparam int PGW_IDENT_LSB     = 3;
  localparam int PGW_DUTY_LSB      = 4;
  localparam int PGW_BIT_LOAD_STABILITY_CHECK_ENABLE    = 4;

  // ----------------------------------------------------------------
  // writable masks (internally connected bits are kept as storage)
  // ----------------------------------------------------------------
  localparam logic [7:0] PGW_MASK_SWMODE  = 8'hC1;
  localparam logic [7:0] PGW_MASK_PROGRAM = 8'hF7;
  localparam logic [7:0] PGW_MASK_DUTY    = 8'h3F;
  localparam logic [7:0] PGW_MASK_MISC2   = 8'h1C;
  localparam logic [7:0] PGW_MASK_CURLIM  = 8'h07;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] PGW_RST_ZERO     = 8'h00;
  localparam logic [7:0] PGW_RST_PROGRAM  = 8'h04;
  localparam logic [1:0] PGW_MODE_SHUTDN  = 2'h0;
  localparam logic [1:0] PGW_MODE_AUTO    = 2'h3;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned PGW_CLK_KHZ     = 200000;
  localparam int unsigned PGW_WD_TICK_MS  = 164;
  localparam int unsigned PGW_WD_TICK_CYC = PGW_WD_TICK_MS * PGW_CLK_KHZ;

endpackage

// [common/pgw_wd_if.sv]
// link between the register bank and its watchdog tick generator
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface pgw_wd_if;
  logic run;
  logic restart;
  logic tick;
  modport gen  (input run, input restart, output tick);
  modport user (output run, output restart, input tick);
endinterface

// [logic/pgw_tick_gen.sv]
// watchdog period generator: one-cycle tick every PERIOD cycles while run
// assumes restart and run come from the register bank's clock domain
`timescale 1ns/1ps
module pgw_tick_gen
  import pgw_pkg::*;
#(
  parameter int unsigned PERIOD = PGW_WD_TICK_CYC,
  parameter int          CW     = 32
) (
  input  wire logic clk,
  input  wire logic resetn,
  pgw_wd_if.gen     wd
);

  logic [CW-1:0] cnt_ff;
  logic          tick_ff;
  logic          wrap;

  assign wrap    = (cnt_ff == CW'(PERIOD - 1));
  assign wd.tick = tick_ff;

  // restart keeps a fresh count from losing part of its first period
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_ff <= '0;
    end else if (!wd.run || wd.restart || wrap) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= cnt_ff + CW'(1);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= wd.run && !wd.restart && wrap;
    end
  end

  AST_TICK_SPACING: assert property (@(posedge clk) disable iff (!resetn)
    tick_ff |=> !tick_ff)
    else $error("watchdog tick longer than one cycle");

endmodule

// [logic/pgw_regs.sv]
// pushbutton, identification, watchdog and configuration register bank
// assumes a serial bus decoder in front that gives one-cycle reg_wr / reg_rd
// strobes with a byte address, and port logic behind that consumes the pulses
`timescale 1ns/1ps
module pgw_regs
  import pgw_pkg::*;
#(
  parameter int unsigned WD_TICK_CYC   = PGW_WD_TICK_CYC,
  parameter logic [4:0]  IDENTITY_CODE = 5'h15, // arbitrary value
  parameter logic [2:0]  REVISION_CODE = 3'h1   // arbitrary value
) (
  input  wire  logic       clk,
  input  wire  logic       resetn,
  input  wire  logic [7:0] reg_addr,
  input  wire  logic       reg_wr,
  input  wire  logic [7:0] reg_wdata,
  input  wire  logic       reg_rd,
  output logic       [7:0] reg_rdata,
  input  wire  logic       legacy_pin,
  input  wire  logic       pwr_on_req,
  input  wire  logic       mode_wr_req,
  input  wire  logic       class_limit_valid,
  input  wire  logic [2:0] class_limit_code,
  output logic             clear_all_interrupts,
  output logic             device_soft_reset,
  output logic             port_reset,
  output logic             pwr_on_grant,
  output logic             mode_wr_grant,
  output logic             hw_mode,
  output logic             mode_force,
  output logic       [1:0] mode_force_value,
  output logic             takeover_irq,
  output logic             large_cap_detect_enable,
  output logic             detection_bypass,
  output logic       [2:0] ac_disconnect_threshold,
  output logic       [1:0] duty_cycle_code,
  output logic             load_stability_check_enable,
  output logic       [2:0] current_limit_code
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic [7:0] swmode_ff, program_ff, duty_ff, misc2_ff, curlim_ff, wdcnt_ff;
  logic       hw_flag_ff, hw_mode_ff, strap_ld_ff;
  logic       clear_all_interrupts_ff, soft_rst_ff, port_rst_ff, force_ff;
  logic [1:0] force_val_ff;
  logic [7:0] rdata_ff, nxt_rdata;
  logic       wr_global, soft_req, wd_en, expire, deny, flag_rd;
  pgw_wd_if   wd ();

  function automatic logic hit(input logic [7:0] a);
    return reg_wr && (reg_addr == a);
  endfunction

  assign wr_global = hit(PGW_ADDR_GLOBAL);
  assign soft_req  = wr_global && reg_wdata[PGW_BIT_SOFT_RST];
  assign wd_en     = swmode_ff[PGW_BIT_WD_EN];
  // a port already under hardware control does not expire again: one takeover, one flag
  assign expire    = wd_en && !hw_mode_ff && wd.tick && (wdcnt_ff <= 8'h01);
  assign deny      = pwr_on_req && hw_mode_ff;
  assign flag_rd   = reg_rd && (reg_addr == PGW_ADDR_TAKEOVR);

  // ----------------------------------------------------------------
  // pushbuttons: one-cycle pulses, register never stores a one
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      clear_all_interrupts_ff  <= 1'b0;
      soft_rst_ff <= 1'b0;
      port_rst_ff <= 1'b0;
    end else begin
      clear_all_interrupts_ff  <= wr_global && reg_wdata[PGW_BIT_CLEAR_ALL_INTERRUPTS];
      soft_rst_ff <= soft_req;
      port_rst_ff <= wr_global && reg_wdata[PGW_BIT_PORT_RST];
    end
  end

  assign clear_all_interrupts = clear_all_interrupts_ff;
  assign device_soft_reset    = soft_rst_ff;
  assign port_reset           = port_rst_ff;

  // ----------------------------------------------------------------
  // watchdog count and tick generator
  // ----------------------------------------------------------------
  assign wd.run     = wd_en;
  assign wd.restart = hit(PGW_ADDR_WDCNT) && (reg_wdata != 8'h00);

  pgw_tick_gen #(
    .PERIOD (WD_TICK_CYC),
    .CW     (32)
  ) u_tick (
    .clk    (clk),
    .resetn (resetn),
    .wd     (wd)
  );

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wdcnt_ff <= PGW_RST_ZERO;
    end else if (soft_req) begin
      wdcnt_ff <= PGW_RST_ZERO;
    end else if (hit(PGW_ADDR_WDCNT)) begin
      wdcnt_ff <= reg_wdata;
    end else if (wd_en && wd.tick && wdcnt_ff != 8'h00) begin
      wdcnt_ff <= wdcnt_ff - 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // hardware-controlled mode and takeover flag
  // ----------------------------------------------------------------
  // leaving hardware control needs the watchdog switched off
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hw_mode_ff <= 1'b0;
    end else if (soft_req) begin
      hw_mode_ff <= 1'b0;
    end else if (expire) begin
      hw_mode_ff <= 1'b1;
    end else if (!wd_en) begin
      hw_mode_ff <= 1'b0;
    end
  end

  // set beats the clear-on-read of the same cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hw_flag_ff <= 1'b0;
    end else if (soft_req) begin
      hw_flag_ff <= 1'b0;
    end else if (expire || deny) begin
      hw_flag_ff <= 1'b1;
    end else if (flag_rd) begin
      hw_flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      force_ff     <= 1'b0;
      force_val_ff <= PGW_MODE_SHUTDN;
    end else begin
      force_ff     <= expire;
      force_val_ff <= swmode_ff[PGW_BIT_FALLBACK] ? PGW_MODE_AUTO : PGW_MODE_SHUTDN;
    end
  end

  assign hw_mode          = hw_mode_ff;
  assign mode_force       = force_ff;
  assign mode_force_value = force_val_ff;
  assign pwr_on_grant     = pwr_on_req && !hw_mode_ff;
  assign mode_wr_grant    = mode_wr_req && !hw_mode_ff;
  assign takeover_irq     = hw_flag_ff && swmode_ff[PGW_BIT_WD_IRQ_EN];

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      swmode_ff <= PGW_RST_ZERO;
      duty_ff   <= PGW_RST_ZERO;
      misc2_ff  <= PGW_RST_ZERO;
    end else if (soft_req) begin
      swmode_ff <= PGW_RST_ZERO;
      duty_ff   <= PGW_RST_ZERO;
      misc2_ff  <= PGW_RST_ZERO;
    end else begin
      if (hit(PGW_ADDR_SWMODE)) swmode_ff <= reg_wdata & PGW_MASK_SWMODE;
      if (hit(PGW_ADDR_DUTY))   duty_ff   <= reg_wdata & PGW_MASK_DUTY;
      if (hit(PGW_ADDR_MISC2))  misc2_ff  <= reg_wdata & PGW_MASK_MISC2;
    end
  end

  // legacy strap is caught by the clock after reset release, never by the reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      strap_ld_ff <= 1'b1;
    end else begin
      strap_ld_ff <= soft_req;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      program_ff <= PGW_RST_PROGRAM;
    end else if (soft_req) begin
      program_ff <= PGW_RST_PROGRAM;
    end else if (strap_ld_ff) begin
      program_ff[PGW_BIT_LARGE_CAP] <= legacy_pin;
    end else if (hit(PGW_ADDR_PROGRAM)) begin
      program_ff <= reg_wdata & PGW_MASK_PROGRAM;
    end
  end

  // classification result wins over a host write in the same cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      curlim_ff <= PGW_RST_ZERO;
    end else if (soft_req) begin
      curlim_ff <= PGW_RST_ZERO;
    end else if (class_limit_valid) begin
      curlim_ff <= {5'h00, class_limit_code};
    end else if (hit(PGW_ADDR_CURLIM)) begin
      curlim_ff <= reg_wdata & PGW_MASK_CURLIM;
    end
  end

  assign large_cap_detect_enable     = program_ff[PGW_BIT_LARGE_CAP];
  assign detection_bypass            = program_ff[PGW_BIT_DET_BYP];
  assign ac_disconnect_threshold     = program_ff[2:0];
  assign duty_cycle_code             = duty_ff[PGW_DUTY_LSB +: 2];
  assign load_stability_check_enable = misc2_ff[PGW_BIT_LOAD_STABILITY_CHECK_ENABLE];
  assign current_limit_code          = curlim_ff[2:0];

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_comb begin
    nxt_rdata = 8'h00;
    case (reg_addr)
      PGW_ADDR_IDENT:   nxt_rdata = {IDENTITY_CODE, REVISION_CODE};
      PGW_ADDR_TAKEOVR: nxt_rdata = {7'h00, hw_flag_ff};
      PGW_ADDR_WDCNT:   nxt_rdata = wdcnt_ff;
      PGW_ADDR_SWMODE:  nxt_rdata = swmode_ff;
      PGW_ADDR_PROGRAM: nxt_rdata = program_ff;
      PGW_ADDR_DUTY:    nxt_rdata = duty_ff;
      PGW_ADDR_MISC2:   nxt_rdata = misc2_ff;
      PGW_ADDR_CURLIM:  nxt_rdata = curlim_ff;
      default:          nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_clr_wr;
    reg_wr && reg_addr == PGW_ADDR_GLOBAL && reg_wdata[PGW_BIT_CLEAR_ALL_INTERRUPTS];
  endsequence

  sequence s_expiry;
    wd_en && !hw_mode_ff && wd.tick && wdcnt_ff == 8'h01 && !reg_wr && !soft_req;
  endsequence

  AST_CLR_PULSE: assert property (@(posedge clk) disable iff (!resetn)
    s_clr_wr |=> clear_all_interrupts ##1 !clear_all_interrupts || $past(reg_wr, 1))
    else $error("clear pulse not one cycle after write");

  AST_SOFT_RESET: assert property (@(posedge clk) disable iff (!resetn)
    soft_req |=> device_soft_reset && swmode_ff == 8'h00 && wdcnt_ff == 8'h00 && !hw_mode)
    else $error("soft reset left a register off default");

  AST_PORT_RESET: assert property (@(posedge clk) disable iff (!resetn)
    (wr_global && reg_wdata[PGW_BIT_PORT_RST]) |=> port_reset)
    else $error("port reset pulse missing");

  AST_GLOBAL_READ_ZERO: assert property (@(posedge clk) disable iff (!resetn)
    (reg_rd && reg_addr == PGW_ADDR_GLOBAL) |=> reg_rdata == 8'h00)
    else $error("pushbutton register read nonzero");

  AST_ID_READ: assert property (@(posedge clk) disable iff (!resetn)
    (reg_rd && reg_addr == PGW_ADDR_IDENT) |=> reg_rdata == {IDENTITY_CODE, REVISION_CODE})
    else $error("identification read wrong");

  AST_EXPIRY: assert property (@(posedge clk) disable iff (!resetn)
    s_expiry |=> hw_mode && hw_flag_ff && wdcnt_ff == 8'h00 && mode_force)
    else $error("expiry did not take over");

  AST_DENY_FLAG: assert property (@(posedge clk) disable iff (!resetn)
    (pwr_on_req && hw_mode && !soft_req) |=> hw_flag_ff)
    else $error("refused power-on did not set flag");

  AST_READ_CLEAR: assert property (@(posedge clk) disable iff (!resetn)
    (flag_rd && !expire && !deny) |=> !hw_flag_ff)
    else $error("flag survived its read");

  AST_FALLBACK: assert property (@(posedge clk) disable iff (!resetn)
    s_expiry |=> mode_force_value == ($past(swmode_ff[PGW_BIT_FALLBACK]) ? PGW_MODE_AUTO : PGW_MODE_SHUTDN))
    else $error("forced mode does not follow fallback bit");

  AST_NO_POWER: assert property (@(posedge clk) disable iff (!resetn)
    hw_mode |-> !pwr_on_grant && !mode_wr_grant)
    else $error("request passed under hardware control");

  AST_IRQ: assert property (@(posedge clk) disable iff (!resetn)
    (swmode_ff[PGW_BIT_WD_IRQ_EN] && $rose(hw_flag_ff)) |-> takeover_irq)
    else $error("takeover interrupt missing");

  AST_COUNT_LOAD: assert property (@(posedge clk) disable iff (!resetn)
    (hit(PGW_ADDR_WDCNT) && !soft_req) |=> wdcnt_ff == $past(reg_wdata))
    else $error("count write not taken");

endmodule

// [test/pgw_host_model.sv]
// host side of the byte-wide register port: single-byte write and read cycles
// assumes the register bank takes a strobe on the rising edge it is seen high
`timescale 1ns/1ps
module pgw_host_model (
  input  wire logic       clk,
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_wdata = 8'h00;
    reg_rd    = 1'b0;
  end

  // ------------------------------------------------------------------
  // bus cycles
  // ------------------------------------------------------------------
  // released lines show the inverse so a stale value never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    @(posedge clk);
    d = reg_rdata;
  endtask
endmodule

// [test/test_pse_general_watchdog_config_regs.sv]
// self-checking bench for the pushbutton / watchdog / configuration bank
// assumes a shortened watchdog period so expiry fits in a short run
`timescale 1ns/1ps
module test_pse_general_watchdog_config_regs;
  import pgw_pkg::*;
  localparam int unsigned WD = 20;
  localparam logic [7:0] EXP_IDENT = {5'h15, 3'h1};

  logic clk = 1'b0, resetn = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_wr, reg_rd, legacy_pin = 1'b0, pwr_on_req = 1'b0, mode_wr_req = 1'b0;
  logic class_limit_valid = 1'b0;
  logic [2:0] class_limit_code = 3'h0;
  logic clear_all_interrupts, device_soft_reset, port_reset, pwr_on_grant, mode_wr_grant;
  logic hw_mode, mode_force, takeover_irq, large_cap_detect_enable, detection_bypass;
  logic load_stability_check_enable;
  logic [1:0] mode_force_value, duty_cycle_code;
  logic [2:0] ac_disconnect_threshold, current_limit_code;
  int n_errors = 0, n_compared = 0;

  always #2.5 clk = ~clk;

  pgw_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  pgw_regs #(.WD_TICK_CYC(WD), .IDENTITY_CODE(5'h15), .REVISION_CODE(3'h1)) uut (
    .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .legacy_pin(legacy_pin), .pwr_on_req(pwr_on_req),
    .mode_wr_req(mode_wr_req), .class_limit_valid(class_limit_valid), .class_limit_code(class_limit_code),
    .clear_all_interrupts(clear_all_interrupts), .device_soft_reset(device_soft_reset),
    .port_reset(port_reset), .pwr_on_grant(pwr_on_grant), .mode_wr_grant(mode_wr_grant),
    .hw_mode(hw_mode), .mode_force(mode_force), .mode_force_value(mode_force_value),
    .takeover_irq(takeover_irq), .large_cap_detect_enable(large_cap_detect_enable),
    .detection_bypass(detection_bypass), .ac_disconnect_threshold(ac_disconnect_threshold),
    .duty_cycle_code(duty_cycle_code), .load_stability_check_enable(load_stability_check_enable),
    .current_limit_code(current_limit_code));

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.rd(a, d);
    chk(d, exp);
  endtask

  // counts the cycles each pushbutton pulse stays high after the write
  task automatic pb(input logic [7:0] d, input logic [7:0] exp_cnt);
    logic [7:0] c;
    c = 8'h00;
    host.wr(PGW_ADDR_GLOBAL, d);
    repeat (4) begin
      #1;
      c = c + {2'h0, 2'(clear_all_interrupts), 2'(device_soft_reset), 2'(port_reset)};
      @(posedge clk);
    end
    chk(c, exp_cnt);
  endtask

  task automatic req(input bit m, output logic g);
    @(posedge clk);
    if (m) mode_wr_req <= 1'b1;
    else pwr_on_req <= 1'b1;
    #1 g = m ? mode_wr_grant : pwr_on_grant;
    @(posedge clk);
    mode_wr_req <= 1'b0;
    pwr_on_req  <= 1'b0;
  endtask

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_reset_values();
    rdchk(PGW_ADDR_IDENT, EXP_IDENT);
    rdchk(PGW_ADDR_TAKEOVR, 8'h00);
    rdchk(PGW_ADDR_WDCNT, 8'h00);
    rdchk(PGW_ADDR_SWMODE, 8'h00);
    rdchk(PGW_ADDR_PROGRAM, 8'h04);
    rdchk(PGW_ADDR_DUTY, 8'h00);
    rdchk(PGW_ADDR_MISC2, 8'h00);
    rdchk(PGW_ADDR_CURLIM, 8'h00);
    chk({5'h0, ac_disconnect_threshold}, 8'h04);
    $display("test reset_values done");
  endtask

  task automatic t_config();
    host.wr(PGW_ADDR_PROGRAM, 8'h35);
    rdchk(PGW_ADDR_PROGRAM, 8'h35);
    chk({5'h0, large_cap_detect_enable, detection_bypass, 1'b0}, 8'h06);
    chk({5'h0, ac_disconnect_threshold}, 8'h05);
    for (int i = 0; i < 4; i++) begin
      host.wr(PGW_ADDR_DUTY, {2'h0, 2'(i), 4'h0});
      // the write lands on the edge the task returns on: look once it has settled
      #1 chk({6'h0, duty_cycle_code}, 8'(i));
    end
    host.wr(PGW_ADDR_MISC2, 8'h10);
    #1 chk({7'h0, load_stability_check_enable}, 8'h01);
    host.wr(PGW_ADDR_CURLIM, 8'h06);
    rdchk(PGW_ADDR_CURLIM, 8'h06);
    @(posedge clk);
    class_limit_valid <= 1'b1;
    class_limit_code  <= 3'h3;
    @(posedge clk);
    class_limit_valid <= 1'b0;
    #1 chk({5'h0, current_limit_code}, 8'h03);
    host.wr(PGW_ADDR_IDENT, 8'hFF);
    rdchk(PGW_ADDR_IDENT, EXP_IDENT);
    host.wr(8'h1D, 8'h00);
    rdchk(8'h1D, 8'h00);
    $display("test config done");
  endtask

  task automatic t_pushbuttons();
    legacy_pin <= 1'b1;
    pb(8'h10, 8'h04);
    rdchk(PGW_ADDR_PROGRAM, 8'h24);
    rdchk(PGW_ADDR_DUTY, 8'h00);
    rdchk(PGW_ADDR_MISC2, 8'h00);
    rdchk(PGW_ADDR_CURLIM, 8'h00);
    legacy_pin <= 1'b0;
    pb(8'h81, 8'h11);
    rdchk(PGW_ADDR_GLOBAL, 8'h00);
    $display("test pushbuttons done");
  endtask

  // refresh at mid-run must push expiry two full periods past the refresh
  task automatic t_watchdog(input bit fb);
    int n;
    logic g;
    host.wr(PGW_ADDR_WDCNT, 8'h02);
    host.wr(PGW_ADDR_SWMODE, {1'b1, fb, 5'h0, fb});
    repeat (WD + 5) @(posedge clk);
    rdchk(PGW_ADDR_WDCNT, 8'h01);
    chk({7'h0, hw_mode}, 8'h00);
    host.wr(PGW_ADDR_WDCNT, 8'h02);
    n = 0;
    while (hw_mode !== 1'b1) begin
      @(posedge clk);
      #1 n++;
      if (n > 4 * WD) begin
        n_errors++;
        tally_and_finish();
      end
    end
    chk(8'(n >= 2 * WD - 3 && n <= 2 * WD + 6), 8'h01);
    chk({6'h0, mode_force, 1'b0}, 8'h02);
    chk({6'h0, mode_force_value}, fb ? 8'h03 : 8'h00);
    chk({7'h0, takeover_irq}, {7'h0, fb});
    rdchk(PGW_ADDR_WDCNT, 8'h00);
    req(1'b0, g);
    chk({7'h0, g}, 8'h00);
    req(1'b1, g);
    chk({7'h0, g}, 8'h00);
    rdchk(PGW_ADDR_TAKEOVR, 8'h01);
    rdchk(PGW_ADDR_TAKEOVR, 8'h00);
    req(1'b0, g);
    rdchk(PGW_ADDR_TAKEOVR, 8'h01);
    // leaving hardware control must grant power-on again without re-arming the flag
    host.wr(PGW_ADDR_SWMODE, 8'h00);
    req(1'b0, g);
    chk({7'h0, g}, 8'h01);
    rdchk(PGW_ADDR_TAKEOVR, 8'h00);
    $display("test watchdog fallback=%0d done", fb);
  endtask

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    t_reset_values();
    t_config();
    t_pushbuttons();
    t_watchdog(1'b1);
    t_watchdog(1'b0);
    tally_and_finish();
  end
endmodule
